// *** hw/status_event_reporting.sv ***
// Status register sets, queues, status byte and local key handling
// Notes on behaviour
// RULE1 - Local key cancels remote and restores panel, unless local lockout holds.
// RULE2 - Effective local key also drops remote indicator and clears user message.
// RULE3 - Seven register sets, each feeding the status byte directly or via another.
// RULE4 - Non-standard sets have read-only condition words following live conditions.
// RULE5 - Operation calculation bit is high exactly while a calculation runs.
// RULE6 - Non-standard sets have writable rising and falling edge select masks.
// RULE7 - Rising select set: a 0 to 1 condition change sets the event bit.
// RULE8 - Falling select set: a 1 to 0 condition change sets the event bit.
// RULE9 - Reading an edge select mask leaves it unchanged.
// RULE10 - Reset and preset set rising masks to ones, falling masks to zeros.
// RULE11 - Event bits stay latched until a clearing operation.
// RULE12 - Summary is OR of event AND enable, feeding another set or status byte.
// RULE13 - Reading an event word clears it; reset and clear-status clear all.
// RULE14 - Enable bit zero keeps its event bit out of the summary.
// RULE15 - Reading an enable word leaves it; reset clears all enables.
// RULE16 - Preset clears operation, questionable, measurement enables; sets trigger, arm, sequence.
// RULE17 - Writing zero to the standard event enable clears it.
// RULE18 - Output queue is a FIFO; message pending bit follows non-empty.
// RULE19 - Controller sends a query then addresses talk to read the queue head.
// RULE20 - Error queue is a FIFO of at most ten messages.
// RULE21 - Error pending bit follows error queue non-empty; reads remove entries.
// RULE22 - Enabled status byte summary bit sets the master summary bit six.
// RULE23 - Serial poll clears request-for-service; master summary stays while summaries set.
// RULE24 - A message arriving at a full error queue is dropped.
module status_event_reporting
  import status_pkg::*;
(
  // Clock and reset
  input  wire logic                 I_MCLK,
  input  wire logic                 I_RST_N,
  // Front panel and remote state
  input  wire logic                 I_LOCAL_KEY,
  input  wire logic                 I_GO_REMOTE,
  input  wire logic                 I_GO_LOCAL,
  input  wire logic                 I_LOCKOUT_SET,
  input  wire logic                 I_LOCKOUT_CLR,
  input  wire logic                 I_USER_MSG_SHOW,
  output logic                      O_REMOTE_INDICATOR,
  output logic                      O_LOCKOUT,
  output logic                      O_USER_MSG_ACTIVE,
  // Live conditions, index 0 unused
  input  wire logic [SET_WIDTH-1:0] I_COND [SET_COUNT],
  input  wire logic                 I_CALC_BUSY,
  // Standard event sources
  input  wire logic [SET_WIDTH-1:0] I_STD_EVENT_SET,
  // Register commands
  input  wire reg_cmd_t             I_REG_CMD,
  input  wire logic                 I_CLEAR_STATUS,
  input  wire logic                 I_PRESET,
  input  wire logic                 I_SRE_WR,
  input  wire logic [7:0]           I_SRE_DATA,
  input  wire logic                 I_SERIAL_POLL,
  output logic [SET_WIDTH-1:0]      O_REG_RDATA,
  // Queues
  input  wire queue_cmd_t           I_OUTQ,
  input  wire queue_cmd_t           I_ERRQ,
  output logic [MSG_WIDTH-1:0]      O_OUTQ_HEAD,
  output logic [MSG_WIDTH-1:0]      O_ERRQ_HEAD,
  output logic                      O_OUTQ_FULL,
  output logic                      O_ERRQ_FULL,
  // Status byte and service request
  output logic [7:0]                O_STATUS_BYTE,
  output logic [7:0]                O_POLL_BYTE,
  output logic                      O_SRQ
);

  logic [SET_WIDTH-1:0] rising_edge_select  [SET_COUNT];
  logic [SET_WIDTH-1:0] falling_edge_select [SET_COUNT];
  logic [SET_WIDTH-1:0] enable_mask         [SET_COUNT];
  logic [SET_WIDTH-1:0] event_latch         [SET_COUNT];
  logic [SET_WIDTH-1:0] cond_prev           [SET_COUNT];
  logic [SET_WIDTH-1:0] cond_now            [SET_COUNT];
  logic [SET_COUNT-1:0] summary;
  logic [7:0]           sre;
  logic                 rqs;
  logic                 prev_request;

  wire logic key_effective = I_LOCAL_KEY && !O_LOCKOUT; // RULE1

  // Remote, lockout and user message state
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_REMOTE_INDICATOR <= 1'b0;
      O_LOCKOUT          <= 1'b0;
      O_USER_MSG_ACTIVE  <= 1'b0;
    end else begin
      if (key_effective || I_GO_LOCAL) begin
        O_REMOTE_INDICATOR <= 1'b0; // RULE1 RULE2
      end else if (I_GO_REMOTE) begin
        O_REMOTE_INDICATOR <= 1'b1;
      end
      if (I_LOCKOUT_SET) begin
        O_LOCKOUT <= 1'b1;
      end else if (I_GO_LOCAL || I_LOCKOUT_CLR) begin
        O_LOCKOUT <= 1'b0;
      end
      if (key_effective) begin
        O_USER_MSG_ACTIVE <= 1'b0; // RULE2
      end else if (I_USER_MSG_SHOW) begin
        O_USER_MSG_ACTIVE <= 1'b1;
      end
    end
  end

  // Which set feeds which: trigger, arm and sequence roll into operation
  wire logic [SET_WIDTH-1:0] oper_feed =
    {{(SET_WIDTH-3){1'b0}}, summary[SET_SEQ], summary[SET_ARM], summary[SET_TRIG]}; // RULE3

  genvar g;
  generate
    for (g = 0; g < SET_COUNT; g++) begin : g_set
      logic [SET_WIDTH-1:0] cond_live;
      logic [SET_WIDTH-1:0] edge_hit;
      logic [SET_WIDTH-1:0] next_event;
      logic                 sel_here;
      logic                 wr_here;
      logic                 rd_event;

      if (g == SET_OPER) begin : g_oper
        assign cond_live = (I_COND[g] & ~(SET_WIDTH'(1) << OPER_CALC_BIT))
                         | (SET_WIDTH'(I_CALC_BUSY) << OPER_CALC_BIT)
                         | oper_feed; // RULE5
      end else begin : g_other
        assign cond_live = I_COND[g]; // RULE4
      end

      assign cond_now[g] = cond_live;
      assign sel_here    = (I_REG_CMD.set == 3'(g));
      assign wr_here     = I_REG_CMD.wr && sel_here;
      assign rd_event    = I_REG_CMD.rd && sel_here && (I_REG_CMD.sel == SEL_EVENT);

      if (g == SET_STD) begin : g_std
        assign edge_hit = I_STD_EVENT_SET;
      end else begin : g_filt
        assign edge_hit = (rising_edge_select[g]  & cond_live & ~cond_prev[g])  // RULE7
                        | (falling_edge_select[g] & ~cond_live & cond_prev[g]); // RULE8
      end

      // New edges win over a read-clear in the same cycle
      assign next_event = ((rd_event || I_CLEAR_STATUS) ? '0 : event_latch[g]) | edge_hit; // RULE11 RULE13
      assign summary[g] = |(event_latch[g] & enable_mask[g]); // RULE12 RULE14

      always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          cond_prev[g]   <= '0;
          event_latch[g] <= '0; // RULE13
        end else begin
          cond_prev[g]   <= cond_live;
          event_latch[g] <= next_event;
        end
      end

      always_ff @(posedge I_MCLK) begin
        if (!I_RST_N || (I_PRESET && g != SET_STD)) begin
          rising_edge_select[g]  <= RISE_RESET; // RULE10
          falling_edge_select[g] <= FALL_RESET;
        end else if (wr_here && g != SET_STD) begin
          if (I_REG_CMD.sel == SEL_RISE) begin
            rising_edge_select[g] <= I_REG_CMD.data; // RULE6
          end
          if (I_REG_CMD.sel == SEL_FALL) begin
            falling_edge_select[g] <= I_REG_CMD.data; // RULE6
          end
        end
      end

      always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          enable_mask[g] <= ENABLE_RESET; // RULE15
        end else if (I_PRESET && g != SET_STD) begin
          enable_mask[g] <= (g >= SET_TRIG) ? ENABLE_ALL : ENABLE_RESET; // RULE16
        end else if (wr_here && I_REG_CMD.sel == SEL_ENABLE) begin
          enable_mask[g] <= I_REG_CMD.data; // RULE17
        end
      end
    end
  endgenerate

  // Read data; only event reads have a side effect
  // Set codes past the last set read as zero rather than an unknown word
  wire logic set_valid = (I_REG_CMD.set < 3'(SET_COUNT));
  wire logic [SET_WIDTH-1:0] cond_rd =
    (I_REG_CMD.set == SET_STD || !set_valid) ? '0 : cond_now[I_REG_CMD.set];
  logic [SET_WIDTH-1:0] rd_mux;
  always_comb begin
    unique case (I_REG_CMD.sel)
      SEL_RISE:   rd_mux = rising_edge_select[I_REG_CMD.set];  // RULE9
      SEL_FALL:   rd_mux = falling_edge_select[I_REG_CMD.set]; // RULE9
      SEL_ENABLE: rd_mux = enable_mask[I_REG_CMD.set];         // RULE15
      SEL_EVENT:  rd_mux = event_latch[I_REG_CMD.set];
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= '0;
    end else if (I_REG_CMD.rd) begin
      O_REG_RDATA <= set_valid ? rd_mux : '0;
    end else begin
      O_REG_RDATA <= cond_rd;
    end
  end

  // Output queue
  logic [MSG_WIDTH-1:0]  outq_mem [OUTQ_DEPTH];
  logic [OUTQ_PTR_W-1:0] outq_rd;
  logic [OUTQ_PTR_W-1:0] outq_wr;
  logic [OUTQ_PTR_W:0]   outq_cnt;
  wire logic outq_empty = (outq_cnt == '0);
  assign O_OUTQ_FULL    = (outq_cnt == (OUTQ_PTR_W+1)'(OUTQ_DEPTH));
  wire logic outq_pop   = I_OUTQ.pop && !outq_empty;
  wire logic outq_push  = I_OUTQ.push && (!O_OUTQ_FULL || outq_pop);

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      outq_rd  <= '0;
      outq_wr  <= '0;
      outq_cnt <= '0;
    end else begin
      if (outq_push) begin
        outq_mem[outq_wr] <= I_OUTQ.data; // RULE18
        outq_wr           <= outq_wr + 1'b1;
      end
      if (outq_pop) begin
        outq_rd <= outq_rd + 1'b1; // RULE19
      end
      outq_cnt <= outq_cnt + (OUTQ_PTR_W+1)'(outq_push) - (OUTQ_PTR_W+1)'(outq_pop);
    end
  end
  assign O_OUTQ_HEAD = outq_empty ? '0 : outq_mem[outq_rd];

  // Error queue, ten entries
  logic [MSG_WIDTH-1:0]  errq_mem [ERRQ_DEPTH];
  logic [ERRQ_PTR_W-1:0] errq_rd;
  logic [ERRQ_PTR_W-1:0] errq_wr;
  logic [ERRQ_PTR_W:0]   errq_cnt;
  wire logic errq_empty = (errq_cnt == '0);
  assign O_ERRQ_FULL    = (errq_cnt == (ERRQ_PTR_W+1)'(ERRQ_DEPTH)); // RULE20
  wire logic errq_pop   = I_ERRQ.pop && !errq_empty;
  wire logic errq_push  = I_ERRQ.push && !O_ERRQ_FULL; // RULE24
  wire logic [ERRQ_PTR_W-1:0] errq_wr_nx =
    (errq_wr == ERRQ_PTR_W'(ERRQ_DEPTH-1)) ? '0 : errq_wr + 1'b1;
  wire logic [ERRQ_PTR_W-1:0] errq_rd_nx =
    (errq_rd == ERRQ_PTR_W'(ERRQ_DEPTH-1)) ? '0 : errq_rd + 1'b1;

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      errq_rd  <= '0;
      errq_wr  <= '0;
      errq_cnt <= '0;
    end else begin
      if (errq_push) begin
        errq_mem[errq_wr] <= I_ERRQ.data; // RULE20
        errq_wr           <= errq_wr_nx;
      end
      if (errq_pop) begin
        errq_rd <= errq_rd_nx; // RULE21
      end
      errq_cnt <= errq_cnt + (ERRQ_PTR_W+1)'(errq_push) - (ERRQ_PTR_W+1)'(errq_pop);
    end
  end
  assign O_ERRQ_HEAD = errq_empty ? '0 : errq_mem[errq_rd];

  // Status byte
  logic [7:0] stb_sum;
  assign stb_sum[STB_MSB] = summary[SET_MEAS];
  assign stb_sum[1]       = 1'b0;
  assign stb_sum[STB_EAV] = !errq_empty; // RULE21
  assign stb_sum[STB_QSB] = summary[SET_QUES];
  assign stb_sum[STB_MAV] = !outq_empty; // RULE18
  assign stb_sum[STB_ESB] = summary[SET_STD];
  assign stb_sum[STB_MSS] = 1'b0;
  assign stb_sum[STB_OSB] = summary[SET_OPER]; // RULE3

  wire logic mss = |(stb_sum & sre); // RULE22

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      sre <= SRE_RESET;
    end else if (I_SRE_WR) begin
      sre <= I_SRE_DATA & ~(8'h01 << STB_MSS);
    end
  end

  // A new enabled request beats a poll in the same cycle
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      rqs          <= 1'b0;
      prev_request <= 1'b0;
    end else begin
      prev_request <= mss;
      if (mss && !prev_request) begin
        rqs <= 1'b1; // RULE22
      end else if (I_SERIAL_POLL || I_CLEAR_STATUS) begin
        rqs <= 1'b0; // RULE23
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_STATUS_BYTE <= '0;
      O_POLL_BYTE   <= '0;
    end else begin
      O_STATUS_BYTE <= stb_sum | (8'(mss) << STB_MSS); // RULE23
      O_POLL_BYTE   <= stb_sum | (8'(rqs) << STB_MSS);
    end
  end
  assign O_SRQ = rqs;

endmodule : status_event_reporting

// *** hw/status_pkg.sv ***
// Shared constants and carrier types for the status reporting block
package status_pkg;

  localparam int SET_COUNT      = 7;
  localparam int SET_WIDTH      = 16;
  localparam int MSG_WIDTH      = 16;
  localparam int ERRQ_DEPTH     = 10;
  localparam int OUTQ_DEPTH     = 8;
  localparam int ERRQ_PTR_W     = 4;
  localparam int OUTQ_PTR_W     = 3;

  // Set indices; the standard event set has no condition or filter
  localparam logic [2:0] SET_STD    = 3'h0;
  localparam logic [2:0] SET_OPER   = 3'h1;
  localparam logic [2:0] SET_QUES   = 3'h2;
  localparam logic [2:0] SET_MEAS   = 3'h3;
  localparam logic [2:0] SET_TRIG   = 3'h4;
  localparam logic [2:0] SET_ARM    = 3'h5;
  localparam logic [2:0] SET_SEQ    = 3'h6;

  // Calculation bit position in the operation condition word
  localparam int OPER_CALC_BIT  = 9;

  // Status byte bit positions
  localparam int STB_MSB        = 0;
  localparam int STB_EAV        = 2;
  localparam int STB_QSB        = 3;
  localparam int STB_MAV        = 4;
  localparam int STB_ESB        = 5;
  localparam int STB_MSS        = 6;
  localparam int STB_OSB        = 7;

  // Reset and preset values
  localparam logic [SET_WIDTH-1:0] RISE_RESET   = 16'hFFFF;
  localparam logic [SET_WIDTH-1:0] FALL_RESET   = 16'h0000;
  localparam logic [SET_WIDTH-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [SET_WIDTH-1:0] ENABLE_ALL   = 16'hFFFF;
  localparam logic [7:0]           SRE_RESET    = 8'h00;

  // Register selected by a write or read command
  typedef enum logic [1:0] {
    SEL_RISE,
    SEL_FALL,
    SEL_ENABLE,
    SEL_EVENT
  } reg_sel_t;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [2:0]           set;
    reg_sel_t             sel;
    logic [SET_WIDTH-1:0] data;
  } reg_cmd_t;

  typedef struct packed {
    logic                 push;
    logic                 pop;
    logic [MSG_WIDTH-1:0] data;
  } queue_cmd_t;

endpackage : status_pkg

// *** test/bus_ctrl_model.sv ***
// Bus controller model: register commands and output queue reads
module bus_ctrl_model
  import status_pkg::*;
(
  // Clock and answers
  input  wire logic                 i_clk,
  input  wire logic [SET_WIDTH-1:0] i_rdata,
  input  wire logic [MSG_WIDTH-1:0] i_head,
  // Requests
  output reg_cmd_t                  o_cmd,
  output queue_cmd_t                o_outq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_cmd = '0;
    o_outq = '0;
  end
  task automatic wr(input logic [2:0] s, input reg_sel_t l, input logic [15:0] v);
    @(posedge i_clk) #1;
    o_cmd = '{1'b1, 1'b0, s, l, v};
    @(posedge i_clk) #1;
    o_cmd = '0;
  endtask : wr
  // Held over two edges; with r low the word shown is the condition word
  task automatic rd(input logic [2:0] s, input reg_sel_t l, input logic r, output logic [15:0] d, output logic [15:0] d2);
    @(posedge i_clk) #1;
    o_cmd = '{1'b0, r, s, l, 16'h0000};
    @(posedge i_clk) #1;
    d = i_rdata;
    @(posedge i_clk) #1;
    d2 = i_rdata;
    o_cmd = '0;
  endtask : rd
  // Queue a response (p high) or talk: take the head, then remove it
  task automatic q(input logic p, input logic [15:0] v, output logic [15:0] d);
    @(posedge i_clk) #1;
    d = i_head;
    o_outq = '{p, !p, v};
    @(posedge i_clk) #1;
    o_outq = '0;
  endtask : q
endmodule : bus_ctrl_model

// *** test/status_properties.sv ***
// Port-level assertions for the status reporting block
module status_checker
  import status_pkg::*;
(
  // Clock, reset and local key
  input wire logic                 I_MCLK,
  input wire logic                 I_RST_N,
  input wire logic                 I_LOCAL_KEY,
  input wire logic                 I_GO_REMOTE,
  input wire logic                 I_GO_LOCAL,
  input wire logic                 I_LOCKOUT_SET,
  input wire logic                 I_LOCKOUT_CLR,
  input wire logic                 I_USER_MSG_SHOW,
  input wire logic                 O_REMOTE_INDICATOR,
  input wire logic                 O_LOCKOUT,
  input wire logic                 O_USER_MSG_ACTIVE,
  // Registers, queues and status byte
  input wire logic                 I_CALC_BUSY,
  input wire reg_cmd_t             I_REG_CMD,
  input wire logic                 I_PRESET,
  input wire logic                 I_CLEAR_STATUS,
  input wire logic [SET_WIDTH-1:0] O_REG_RDATA,
  input wire queue_cmd_t           I_OUTQ,
  input wire queue_cmd_t           I_ERRQ,
  input wire logic                 O_OUTQ_FULL,
  input wire logic                 O_ERRQ_FULL,
  input wire logic [MSG_WIDTH-1:0] O_ERRQ_HEAD,
  input wire logic [7:0]           O_STATUS_BYTE
);
  timeunit 1ns;
  timeprecision 100ps;
  // Status byte positions of the two queue summaries
  localparam int ERR_BIT = 2;
  localparam int OUT_BIT = 4;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  a_key_leaves_remote: assert property (
    I_LOCAL_KEY && !O_LOCKOUT && !I_LOCKOUT_SET && !I_GO_REMOTE |=> !O_REMOTE_INDICATOR)
    else $error("local key left remote state on");
  a_lockout_holds: assert property (
    I_LOCAL_KEY && O_LOCKOUT && O_REMOTE_INDICATOR && !I_GO_LOCAL && !I_LOCKOUT_CLR |=> O_REMOTE_INDICATOR)
    else $error("local key acted under lockout");
  a_key_drops_message: assert property (
    I_LOCAL_KEY && O_REMOTE_INDICATOR && !O_LOCKOUT && !I_LOCKOUT_SET && !I_USER_MSG_SHOW && !I_GO_REMOTE
    |=> !O_USER_MSG_ACTIVE) else $error("user message kept after local key");
  a_calc_bit_live: assert property (
    !I_REG_CMD.rd && I_REG_CMD.set == SET_OPER |=> O_REG_RDATA[OPER_CALC_BIT] == $past(I_CALC_BUSY))
    else $error("calculation bit does not follow busy");
  a_mask_read_keeps: assert property (
    I_REG_CMD.rd && !I_REG_CMD.wr && I_REG_CMD.sel != SEL_EVENT && !I_PRESET
    ##1 $stable(I_REG_CMD) && !I_PRESET |=> $stable(O_REG_RDATA)) else $error("mask changed by a read");
  a_output_pending: assert property (
    I_OUTQ.push && !I_OUTQ.pop && !O_OUTQ_FULL && !I_CLEAR_STATUS ##1 !I_CLEAR_STATUS && !I_OUTQ.pop
    |=> O_STATUS_BYTE[OUT_BIT]) else $error("output pending bit not set");
  a_error_pending: assert property (
    I_ERRQ.push && !I_ERRQ.pop && !O_ERRQ_FULL && !I_CLEAR_STATUS ##1 !I_CLEAR_STATUS && !I_ERRQ.pop
    |=> O_STATUS_BYTE[ERR_BIT]) else $error("error pending bit not set");
  a_full_queue_drops: assert property (
    O_ERRQ_FULL && I_ERRQ.push && !I_ERRQ.pop && !I_CLEAR_STATUS |=> O_ERRQ_FULL && $stable(O_ERRQ_HEAD))
    else $error("full error queue changed by a push");
endmodule : status_checker

bind status_event_reporting status_checker chk_i (.*);

// *** test/testbench.sv ***
// Self-checking testbench for the status reporting block
module testbench;
  import status_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ERR_BIT = 2;
  localparam int OUT_BIT = 4;
  logic                 I_MCLK, I_RST_N, I_LOCAL_KEY, I_GO_REMOTE, I_GO_LOCAL, I_LOCKOUT_SET, I_LOCKOUT_CLR;
  logic                 I_USER_MSG_SHOW, I_CALC_BUSY, I_CLEAR_STATUS, I_PRESET, I_SRE_WR, I_SERIAL_POLL, O_SRQ;
  logic                 O_REMOTE_INDICATOR, O_LOCKOUT, O_USER_MSG_ACTIVE, O_OUTQ_FULL, O_ERRQ_FULL;
  logic [SET_WIDTH-1:0] I_COND [SET_COUNT];
  logic [SET_WIDTH-1:0] I_STD_EVENT_SET, O_REG_RDATA, O_OUTQ_HEAD, O_ERRQ_HEAD, d, d2;
  logic [7:0]           I_SRE_DATA, O_STATUS_BYTE, O_POLL_BYTE;
  reg_cmd_t             I_REG_CMD;
  queue_cmd_t           I_OUTQ, I_ERRQ;
  int                   errors, n_checks;

  status_event_reporting DUT (.*);
  bus_ctrl_model bc (.i_clk(I_MCLK), .i_rdata(O_REG_RDATA), .i_head(O_OUTQ_HEAD), .o_cmd(I_REG_CMD), .o_outq(I_OUTQ));

  initial begin
    I_MCLK = 1'b0;
    forever #12.5 I_MCLK = ~I_MCLK;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic masks(input logic pre);
    for (int s = 1; s < SET_COUNT; s++) begin
      bc.rd(3'(s), SEL_RISE, 1'b1, d, d2);
      chk(d, RISE_RESET);
      chk(d2, d);
      bc.rd(3'(s), SEL_FALL, 1'b1, d, d2);
      chk(d, FALL_RESET);
      bc.rd(3'(s), SEL_ENABLE, 1'b1, d, d2);
      chk(d, (pre && s >= SET_TRIG) ? ENABLE_ALL : ENABLE_RESET);
    end
  endtask : masks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {I_RST_N, I_LOCAL_KEY, I_GO_REMOTE, I_GO_LOCAL, I_LOCKOUT_SET, I_LOCKOUT_CLR, I_USER_MSG_SHOW} = '0;
    {I_CALC_BUSY, I_CLEAR_STATUS, I_PRESET, I_SRE_WR, I_SERIAL_POLL, I_SRE_DATA, I_STD_EVENT_SET, I_ERRQ} = '0;
    foreach (I_COND[i]) I_COND[i] = '0;
    cyc(20);
    I_RST_N = 1'b1;
    masks(1'b0);
    $display("test reset values done");
    bc.wr(SET_MEAS, SEL_ENABLE, 16'h0001);
    I_COND[SET_MEAS] = 16'h0001;
    cyc(3);
    chk(O_STATUS_BYTE[STB_MSB], 1'b1);
    bc.rd(SET_MEAS, SEL_EVENT, 1'b1, d, d2);
    chk(d, 16'h0001);
    chk(d2, 16'h0000);
    cyc(2);
    chk(O_STATUS_BYTE[STB_MSB], 1'b0);
    bc.wr(SET_MEAS, SEL_ENABLE, 16'h0000);
    bc.wr(SET_MEAS, SEL_RISE, 16'h0000);
    bc.wr(SET_MEAS, SEL_FALL, 16'h0001);
    I_COND[SET_MEAS] = 16'h0000;
    cyc(3);
    chk(O_STATUS_BYTE[STB_MSB], 1'b0);
    bc.rd(SET_MEAS, SEL_EVENT, 1'b1, d, d2);
    chk(d, 16'h0001);
    I_COND[SET_MEAS] = 16'h0001;
    bc.rd(SET_MEAS, SEL_EVENT, 1'b1, d, d2);
    chk(d, 16'h0000);
    I_COND[SET_MEAS] = 16'h0000;
    cyc(3);
    pulse(I_CLEAR_STATUS);
    bc.rd(SET_MEAS, SEL_EVENT, 1'b1, d, d2);
    chk(d, 16'h0000);
    $display("test transitions done");
    bc.wr(SET_OPER, SEL_ENABLE, 16'hFFFF);
    pulse(I_PRESET);
    masks(1'b1);
    bc.wr(SET_STD, SEL_ENABLE, 16'h0020);
    bc.rd(SET_STD, SEL_ENABLE, 1'b1, d, d2);
    chk(d, 16'h0020);
    bc.wr(SET_STD, SEL_ENABLE, 16'h0000);
    bc.rd(SET_STD, SEL_ENABLE, 1'b1, d, d2);
    chk(d, 16'h0000);
    I_STD_EVENT_SET = 16'h0020;
    cyc(1);
    I_STD_EVENT_SET = '0;
    bc.rd(SET_STD, SEL_EVENT, 1'b1, d, d2);
    chk(d, 16'h0020);
    chk(d2, 16'h0000);
    I_CALC_BUSY = 1'b1;
    bc.rd(SET_OPER, SEL_RISE, 1'b0, d, d2);
    chk(d, 16'h0001 << OPER_CALC_BIT);
    I_CALC_BUSY = 1'b0;
    bc.rd(SET_OPER, SEL_RISE, 1'b0, d, d2);
    chk(d, 16'h0000);
    $display("test preset and condition done");
    for (int i = 0; i <= ERRQ_DEPTH; i++) begin
      I_ERRQ = '{1'b1, 1'b0, 16'h0100 + 16'(i)};
      cyc(1);
    end
    I_ERRQ = '0;
    chk({O_ERRQ_FULL, O_STATUS_BYTE[ERR_BIT]}, 2'b11);
    for (int i = 0; i < ERRQ_DEPTH; i++) begin
      chk(O_ERRQ_HEAD, 16'h0100 + 16'(i));
      I_ERRQ = '{1'b0, 1'b1, 16'h0000};
      cyc(1);
    end
    I_ERRQ = '0;
    cyc(2);
    chk(O_ERRQ_HEAD, 16'h0000);
    chk(O_STATUS_BYTE[ERR_BIT], 1'b0);
    bc.q(1'b1, 16'hA5A5, d);
    bc.q(1'b1, 16'h5A5A, d);
    cyc(1);
    chk(O_STATUS_BYTE[OUT_BIT], 1'b1);
    bc.q(1'b0, 16'h0000, d);
    chk(d, 16'hA5A5);
    bc.q(1'b0, 16'h0000, d);
    chk(d, 16'h5A5A);
    cyc(2);
    chk(O_STATUS_BYTE[OUT_BIT], 1'b0);
    $display("test queues done");
    pulse(I_GO_REMOTE);
    pulse(I_USER_MSG_SHOW);
    chk({O_REMOTE_INDICATOR, O_USER_MSG_ACTIVE}, 2'b11);
    pulse(I_LOCAL_KEY);
    chk({O_REMOTE_INDICATOR, O_USER_MSG_ACTIVE}, 2'b00);
    pulse(I_GO_REMOTE);
    pulse(I_LOCKOUT_SET);
    pulse(I_LOCAL_KEY);
    chk({O_REMOTE_INDICATOR, O_LOCKOUT}, 2'b11);
    pulse(I_GO_LOCAL);
    chk({O_REMOTE_INDICATOR, O_LOCKOUT}, 2'b00);
    $display("test local key done");
    I_SRE_DATA = 8'h01;
    pulse(I_SRE_WR);
    bc.wr(SET_MEAS, SEL_ENABLE, 16'h0001);
    I_COND[SET_MEAS] = 16'h0001;
    cyc(4);
    chk({O_STATUS_BYTE[STB_MSS], O_SRQ}, 2'b11);
    chk(O_POLL_BYTE, 8'h41);
    pulse(I_SERIAL_POLL);
    cyc(1);
    chk({O_STATUS_BYTE[STB_MSS], O_SRQ}, 2'b10);
    chk(O_POLL_BYTE, 8'h01);
    $display("test service request done");
    end_of_test;
  end

  // The sequence needs well under a thousand cycles; allow four thousand
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule : testbench
